//--- core/i2cst_params.svh
// constants for the serial bus status, clock-rate and timeout register block
`ifndef I2CST_PARAMS_SVH
`define I2CST_PARAMS_SVH
`define I2CST_AW 12
`define I2CST_IDX_DATA 10'h0BC
`define I2CST_IDX_STATUS 10'h0BD
`define I2CST_IDX_RATE 10'h0BE
`define I2CST_IDX_TIMER 10'h0BF
`define I2CST_IDX_CTRL 10'h0C0
`define I2CST_IDX_IRQ_STAT 10'h0C1
`define I2CST_IDX_IRQ_MASK 10'h0C2
`define I2CST_CODE_IDLE 8'hF8
`define I2CST_CODE_BUS_ERR 8'h00
`define I2CST_CODE_START 8'h08
`define I2CST_CODE_BYTE 8'h50
`define I2CST_CODE_STOP 8'hA0
`define I2CST_CODE_LOW_ZERO 3'h0
`define I2CST_TMR_ENABLE_BIT 2
`define I2CST_TMR_TIMEOUT_PRESCALE_SELECT_BIT 1
`define I2CST_TMR_FLAG_BIT 0
`define I2CST_CTRL_ENABLE_BIT 0
`define I2CST_CTRL_TX_BIT 1
`define I2CST_IRQ_SERIAL_BIT 0
`define I2CST_IRQ_TIMEOUT_BIT 1
`define I2CST_TMR_WIDTH 14
`define I2CST_TMR_MAX 14'h3FFF
`define I2CST_PRESCALE_LAST 2'h3
`define I2CST_FRAME_BITS 4'h9
`define I2CST_ACK_BIT 4'h8
`define I2CST_RESP_OKAY 2'h0
`define I2CST_RESP_SLVERR 2'h2
`endif

//--- core/i2cst_pkg.sv
// types shared by the serial bus register block
package i2cst_pkg;
	typedef enum logic [2:0] {
		I2CST_TX_IDLE = 3'h1,
		I2CST_TX_LOW = 3'h2,
		I2CST_TX_HIGH = 3'h4
	} i2cst_tx_state_t;
	typedef logic [7:0] i2cst_byte_t;
endpackage : i2cst_pkg

//--- core/i2cst_mon_if.sv
// events passed from the bus monitor to the register block
interface i2cst_mon_if;
	logic start_seen;
	logic stop_seen;
	logic byte_done;
	logic bus_error;
	logic [7:0] rx_byte;
	logic monitor_enable;
	modport monitor (output start_seen, stop_seen, byte_done, bus_error, rx_byte, input monitor_enable);
	modport regs (input start_seen, stop_seen, byte_done, bus_error, rx_byte, output monitor_enable);
endinterface : i2cst_mon_if

//--- core/i2cst_bus_monitor.sv
// watches scl/sda, finds start/stop, collects bytes and flags misplaced conditions
`include "i2cst_params.svh"
module i2cst_bus_monitor
	import i2cst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl_i,
	input wire logic sda_i,
	i2cst_mon_if.monitor mon
);
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic in_frame_q, in_frame_d;
	logic [7:0] shift_q, shift_d;
	logic start_q, start_d, stop_q, stop_d, done_q, done_d, err_q, err_d;
	logic [7:0] rx_q, rx_d;
	logic is_start, is_stop, scl_rise;

	assign is_start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign is_stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	assign scl_rise = scl_s_q && !scl_p_q;

	always_comb
	begin
		bit_cnt_d = bit_cnt_q;
		in_frame_d = in_frame_q;
		shift_d = shift_q;
		rx_d = rx_q;
		start_d = 1'b0;
		stop_d = 1'b0;
		done_d = 1'b0;
		err_d = 1'b0;
		if (!mon.monitor_enable)
		begin
			bit_cnt_d = 4'h0;
			in_frame_d = 1'b0;
		end
		else if (is_start || is_stop)
		begin
			// a stop or repeated start lives in the high half of a byte's first bit or its ack bit; bits two to eight are misplaced
			if (in_frame_q && bit_cnt_q > 4'h1)
				err_d = 1'b1;
			else if (is_start)
				start_d = 1'b1;
			else
				stop_d = 1'b1;
			bit_cnt_d = 4'h0;
			in_frame_d = is_start && !(in_frame_q && bit_cnt_q > 4'h1);
		end
		else if (scl_rise && in_frame_q)
		begin
			if (bit_cnt_q == `I2CST_ACK_BIT)
			begin
				bit_cnt_d = 4'h0;
				done_d = 1'b1;
				rx_d = shift_q;
			end
			else
			begin
				bit_cnt_d = bit_cnt_q + 4'h1;
				shift_d = {shift_q[6:0], sda_s_q};
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			bit_cnt_q <= 4'h0;
			in_frame_q <= 1'b0;
			shift_q <= 8'h00;
			rx_q <= 8'h00;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			bit_cnt_q <= bit_cnt_d;
			in_frame_q <= in_frame_d;
			shift_q <= shift_d;
			rx_q <= rx_d;
			start_q <= start_d;
			stop_q <= stop_d;
			done_q <= done_d;
			err_q <= err_d;
		end
	end

	assign mon.start_seen = start_q;
	assign mon.stop_seen = stop_q;
	assign mon.byte_done = done_q;
	assign mon.bus_error = err_q;
	assign mon.rx_byte = rx_q;
endmodule : i2cst_bus_monitor

//--- core/i2cst_regs.sv
// serial bus register block: data, status code, clock rate, timeout counter, axi4-lite slave
// Functional notes
// - status register always reads zero in its three low bits.
// - upper five status bits carry the current state code, one of five.
// - idle code never raises the serial interrupt flag.
// - entering any non-idle state sets the serial interrupt flag.
// - code shows one cycle after flag set, stays one cycle after clear.
// - bus error is reported as code zero.
// - start or stop inside the second to eighth bit of a byte is a bus error; first bit and ack bit are not.
// - eight-bit data register holds byte sent or byte received.
// - eight-bit clock-rate register sets the generated serial clock rate.
// - timer control: enable bit 2, prescale bit 1, overflow flag bit 0.
// - 14-bit counter runs with both enables, stops and clears on serial flag.
// - counter ticks every clock, or every fourth clock with prescale set.
// - overflow sets flag and interrupt; software clears flag and serial flag.
`include "i2cst_params.svh"
module i2cst_regs
	import i2cst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`I2CST_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`I2CST_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq
);
	i2cst_mon_if mon ();

	i2cst_bus_monitor u_mon (
		.aclk(aclk),
		.aresetn(aresetn),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.mon(mon)
	);

	function automatic logic [9:0] reg_index(input logic [`I2CST_AW-1:0] addr);
		reg_index = addr[`I2CST_AW-1:2];
	endfunction : reg_index

	function automatic logic reg_mapped(input logic [`I2CST_AW-1:0] addr);
		logic [9:0] idx;
		idx = reg_index(addr);
		reg_mapped = (idx >= `I2CST_IDX_DATA && idx <= `I2CST_IDX_IRQ_MASK) && addr[1:0] == 2'h0;
	endfunction : reg_mapped

	// bus slave state
	logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [`I2CST_AW-1:0] awaddr_q, awaddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wlane_q, wlane_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic do_write, do_read;
	logic [9:0] widx;
	// register and core state
	i2cst_byte_t data_q, data_d, rate_q, rate_d, code_q, code_d, shown_q, shown_d;
	logic ten_q, ten_d, timeout_prescale_select_q, timeout_prescale_select_d, tif_q, tif_d, interface_enable_q, interface_enable_d;
	logic [1:0] ist_q, ist_d, imask_q, imask_d;
	logic [`I2CST_TMR_WIDTH-1:0] tmr_q, tmr_d;
	logic [1:0] pre_q, pre_d;
	i2cst_tx_state_t tx_q, tx_d;
	logic [7:0] half_q, half_d;
	logic [3:0] tbit_q, tbit_d;
	logic new_event, overflow, tick;
	i2cst_byte_t event_code;
	logic [7:0] tmr_ctrl_rd;

	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign do_read = s_axi_arvalid && !rvalid_q;
	assign widx = reg_index(awaddr_q);
	assign mon.monitor_enable = interface_enable_q;

	// bus events mapped to state codes, error first
	always_comb
	begin
		new_event = 1'b1;
		event_code = `I2CST_CODE_IDLE;
		if (mon.bus_error)
			event_code = `I2CST_CODE_BUS_ERR;
		else if (mon.byte_done)
			event_code = `I2CST_CODE_BYTE;
		else if (mon.start_seen)
			event_code = `I2CST_CODE_START;
		else if (mon.stop_seen)
			event_code = `I2CST_CODE_STOP;
		else
			new_event = 1'b0;
	end

	// counter and its prescaler
	assign tick = !timeout_prescale_select_q || pre_q == `I2CST_PRESCALE_LAST;
	assign overflow = ten_q && interface_enable_q && !ist_q[`I2CST_IRQ_SERIAL_BIT] && tick && tmr_q == `I2CST_TMR_MAX;

	always_comb
	begin
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		awaddr_d = awaddr_q;
		wbyte_d = wbyte_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_awvalid && !aw_full_q)
		begin
			aw_full_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_full_q)
		begin
			w_full_d = 1'b1;
			wbyte_d = s_axi_wdata[7:0];
			wlane_d = s_axi_wstrb[0];
		end
		if (do_write)
		begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = reg_mapped(awaddr_q) ? `I2CST_RESP_OKAY : `I2CST_RESP_SLVERR;
		end
		else if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (do_read)
		begin
			rvalid_d = 1'b1;
			rresp_d = reg_mapped(s_axi_araddr) ? `I2CST_RESP_OKAY : `I2CST_RESP_SLVERR;
			rdata_d = 32'h0000_0000;
			if (reg_mapped(s_axi_araddr))
			begin
				case (reg_index(s_axi_araddr))
					`I2CST_IDX_DATA: rdata_d[7:0] = data_q;
					`I2CST_IDX_STATUS: rdata_d[7:0] = {shown_q[7:3], `I2CST_CODE_LOW_ZERO};
					`I2CST_IDX_RATE: rdata_d[7:0] = rate_q;
					`I2CST_IDX_TIMER: rdata_d[7:0] = tmr_ctrl_rd;
					`I2CST_IDX_CTRL: rdata_d[1:0] = {tx_q != I2CST_TX_IDLE, interface_enable_q};
					`I2CST_IDX_IRQ_STAT: rdata_d[1:0] = ist_q;
					`I2CST_IDX_IRQ_MASK: rdata_d[1:0] = imask_q;
					default: rdata_d = 32'h0000_0000;
				endcase
			end
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
	end

	always_comb
	begin
		tmr_ctrl_rd = 8'h00;
		tmr_ctrl_rd[`I2CST_TMR_ENABLE_BIT] = ten_q;
		tmr_ctrl_rd[`I2CST_TMR_TIMEOUT_PRESCALE_SELECT_BIT] = timeout_prescale_select_q;
		tmr_ctrl_rd[`I2CST_TMR_FLAG_BIT] = tif_q;
	end

	always_comb
	begin
		logic wr;
		wr = do_write && wlane_q;
		data_d = data_q;
		rate_d = rate_q;
		ten_d = ten_q;
		timeout_prescale_select_d = timeout_prescale_select_q;
		tif_d = tif_q;
		interface_enable_d = interface_enable_q;
		imask_d = imask_q;
		ist_d = ist_q;
		code_d = code_q;
		tmr_d = tmr_q;
		pre_d = pre_q;
		tx_d = tx_q;
		half_d = half_q;
		tbit_d = tbit_q;
		// software side; status register writes fall through untouched
		if (wr)
		begin
			case (widx)
				`I2CST_IDX_DATA: if (tx_q == I2CST_TX_IDLE) data_d = wbyte_q;
				`I2CST_IDX_RATE: rate_d = wbyte_q;
				`I2CST_IDX_TIMER:
				begin
					ten_d = wbyte_q[`I2CST_TMR_ENABLE_BIT];
					timeout_prescale_select_d = wbyte_q[`I2CST_TMR_TIMEOUT_PRESCALE_SELECT_BIT];
					if (!wbyte_q[`I2CST_TMR_FLAG_BIT])
						tif_d = 1'b0;
				end
				`I2CST_IDX_CTRL:
				begin
					interface_enable_d = wbyte_q[`I2CST_CTRL_ENABLE_BIT];
					if (wbyte_q[`I2CST_CTRL_TX_BIT] && interface_enable_q && tx_q == I2CST_TX_IDLE)
					begin
						tx_d = I2CST_TX_LOW;
						half_d = 8'h00;
						tbit_d = 4'h0;
					end
				end
				`I2CST_IDX_IRQ_STAT: ist_d = ist_q & ~wbyte_q[1:0];
				`I2CST_IDX_IRQ_MASK: imask_d = wbyte_q[1:0];
				default: ;
			endcase
		end
		// hardware sets win over software clears
		if (new_event && event_code != `I2CST_CODE_IDLE)
		begin
			code_d = event_code;
			ist_d[`I2CST_IRQ_SERIAL_BIT] = 1'b1;
		end
		if (mon.byte_done && tx_q == I2CST_TX_IDLE)
			data_d = mon.rx_byte;
		// timeout counter
		pre_d = pre_q + 2'h1;
		if (ist_q[`I2CST_IRQ_SERIAL_BIT] || !ten_q || !interface_enable_q)
		begin
			tmr_d = '0;
			pre_d = 2'h0;
		end
		else if (tick)
			tmr_d = tmr_q + 14'h0001;
		if (overflow)
		begin
			tif_d = 1'b1;
			ist_d[`I2CST_IRQ_TIMEOUT_BIT] = 1'b1;
		end
		// transmit: clock halves last rate+1 cycles, ninth bit leaves sda free for ack
		case (tx_q)
			I2CST_TX_IDLE: ;
			I2CST_TX_LOW, I2CST_TX_HIGH:
			begin
				half_d = half_q + 8'h01;
				if (half_q == rate_q)
				begin
					half_d = 8'h00;
					if (tx_q == I2CST_TX_LOW)
						tx_d = I2CST_TX_HIGH;
					else if (tbit_q == `I2CST_ACK_BIT)
						tx_d = I2CST_TX_IDLE;
					else
					begin
						tx_d = I2CST_TX_LOW;
						tbit_d = tbit_q + 4'h1;
					end
				end
			end
			default: tx_d = I2CST_TX_IDLE;
		endcase
		if (!interface_enable_q)
			tx_d = I2CST_TX_IDLE;
	end

	// the shown code lags the flag by one cycle both ways
	assign shown_d = ist_q[`I2CST_IRQ_SERIAL_BIT] ? code_q : `I2CST_CODE_IDLE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `I2CST_RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= `I2CST_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			data_q <= 8'h00;
			rate_q <= 8'h00;
			code_q <= `I2CST_CODE_IDLE;
			shown_q <= `I2CST_CODE_IDLE;
			ten_q <= 1'b0;
			timeout_prescale_select_q <= 1'b0;
			tif_q <= 1'b0;
			interface_enable_q <= 1'b0;
			ist_q <= 2'h0;
			imask_q <= 2'h0;
			tmr_q <= '0;
			pre_q <= 2'h0;
			tx_q <= I2CST_TX_IDLE;
			half_q <= 8'h00;
			tbit_q <= 4'h0;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awaddr_q <= awaddr_d;
			wbyte_q <= wbyte_d;
			wlane_q <= wlane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			data_q <= data_d;
			rate_q <= rate_d;
			code_q <= code_d;
			shown_q <= shown_d;
			ten_q <= ten_d;
			timeout_prescale_select_q <= timeout_prescale_select_d;
			tif_q <= tif_d;
			interface_enable_q <= interface_enable_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			tmr_q <= tmr_d;
			pre_q <= pre_d;
			tx_q <= tx_d;
			half_q <= half_d;
			tbit_q <= tbit_d;
		end
	end

	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	// open drain: only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = (tx_q == I2CST_TX_LOW);
	assign sda_oe = (tx_q != I2CST_TX_IDLE) && tbit_q != `I2CST_ACK_BIT && !data_q[3'h7 - tbit_q[2:0]];
	assign irq = |(ist_q & imask_q);
endmodule : i2cst_regs

//--- verif/i2cst_regs_asserts.sv
// port-level checks for the serial bus register block
`include "i2cst_params.svh"
module i2cst_regs_asserts
	import i2cst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`I2CST_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_o,
	input wire logic sda_o
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic status_rd;
	logic unmapped_rd;
	assign status_rd = s_axi_araddr == {`I2CST_IDX_STATUS, 2'h0};
	// anything past the last register or before the first one is unmapped
	assign unmapped_rd = s_axi_araddr > {`I2CST_IDX_IRQ_MASK, 2'h0} || s_axi_araddr < {`I2CST_IDX_DATA, 2'h0};
	sequence write_pair_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence read_take_s;
		s_axi_arvalid && s_axi_arready;
	endsequence
	write_answer_a: assert property (write_pair_s |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after the request");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	read_answer_a: assert property (read_take_s |=> s_axi_rvalid)
		else $error("read data not one cycle after the address");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before rready");
	rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released after rready");
	read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	status_low_a: assert property (read_take_s ##0 status_rd |=> s_axi_rdata[2:0] == `I2CST_CODE_LOW_ZERO)
		else $error("status low bits not zero");
	unmapped_read_a: assert property (read_take_s ##0 unmapped_rd |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	open_drain_a: assert property (!scl_o && !sda_o)
		else $error("bus pin driven high");
endmodule : i2cst_regs_asserts
bind i2cst_regs i2cst_regs_asserts i_i2cst_regs_asserts (.*);

//--- verif/i2cst_bus_partner.sv
// pulled-up two-wire bus with a far-side device that makes start, stop and data bits
module i2cst_bus_partner
	import i2cst_pkg::*;
(
	input wire logic aclk,
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl_line,
	output logic sda_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_low_q = 1'h0;
	logic sda_low_q = 1'h0;
	// released lines go high through the pull-ups, never a stale level
	assign scl_line = !(scl_oe || scl_low_q);
	assign sda_line = !(sda_oe || sda_low_q);
	// each phase outlasts the two-stage input synchroniser by far
	task automatic drive(input logic c, input logic d);
		@(posedge aclk);
		scl_low_q <= !c;
		sda_low_q <= !d;
		repeat (8) @(posedge aclk);
	endtask : drive
	task automatic start_cond();
		drive(1'h1, 1'h1);
		drive(1'h1, 1'h0);
		drive(1'h0, 1'h0);
	endtask : start_cond
	task automatic stop_cond();
		drive(1'h0, 1'h0);
		drive(1'h1, 1'h0);
		drive(1'h1, 1'h1);
	endtask : stop_cond
	task automatic send_bits(input logic [8:0] v, input int n);
		for (int i = 0; i < n; i++)
		begin
			drive(1'h0, v[8-i]);
			drive(1'h1, v[8-i]);
			drive(1'h0, v[8-i]);
		end
	endtask : send_bits
endmodule : i2cst_bus_partner

//--- verif/i2cst_regs_test.sv
// self-checking bench for the serial bus register block
`include "i2cst_params.svh"
module i2cst_regs_test
	import i2cst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, irq, scl_w, sda_w;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int miscompares = 0;
	int num_checks = 0;
	int scl_low_n = 0;
	int sda_low_n = 0;
	i2cst_regs i_i2cst_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl_w), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	i2cst_bus_partner i_i2cst_bus_partner (.aclk(aclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_w),
		.sda_line(sda_w));
	initial
	begin
		forever #50 aclk = ~aclk;
	end
	// cycles in which the block pulls each line low, counted where the pins have settled
	always @(negedge aclk)
	begin
		if (scl_oe === 1'h1)
			scl_low_n <= scl_low_n + 1;
		if (sda_oe === 1'h1)
			sda_low_n <= sda_low_n + 1;
	end
	task automatic conclude();
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_up(input int n);
		if (n >= 2000)
		begin
			miscompares++;
			conclude();
		end
	endtask : give_up
	// waits for a level at the falling edge, where it has settled
	task automatic await(ref logic s);
		int n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (s !== 1'h1 && n < 2000);
		give_up(n);
	endtask : await
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er = `I2CST_RESP_OKAY);
		logic aw_hit, w_hit;
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		aw_hit = 1'h0;
		w_hit = 1'h0;
		for (n = 0; n < 2000 && !(aw_hit && w_hit); n++)
		begin
			@(negedge aclk);
			aw_hit = aw_hit || awready;
			w_hit = w_hit || wready;
			@(posedge aclk);
			if (aw_hit)
				awvalid <= 1'h0;
			if (w_hit)
				wvalid <= 1'h0;
		end
		give_up(n);
		await(bvalid);
		chk({30'h0, bresp}, {30'h0, er});
		@(posedge aclk);
		bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er = `I2CST_RESP_OKAY);
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		await(arready);
		@(posedge aclk);
		arvalid <= 1'h0;
		await(rvalid);
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
		@(posedge aclk);
		rready <= 1'h0;
	endtask : rd
	task automatic irq_is(input logic e);
		@(negedge aclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : irq_is
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`I2CST_IDX_DATA, 32'h0);
		rd(`I2CST_IDX_STATUS, 32'hF8);
		rd(`I2CST_IDX_RATE, 32'h0);
		wr(`I2CST_IDX_DATA, 32'hFFFFFF5A);
		rd(`I2CST_IDX_DATA, 32'h5A);
		wr(`I2CST_IDX_RATE, 32'hC3);
		rd(`I2CST_IDX_RATE, 32'hC3);
		wr(`I2CST_IDX_TIMER, 32'hFF);
		rd(`I2CST_IDX_TIMER, 32'h6);
		wr(`I2CST_IDX_STATUS, 32'h0);
		rd(`I2CST_IDX_STATUS, 32'hF8);
		wr(10'h0C3, 32'h1, `I2CST_RESP_SLVERR);
		rd(10'h0C3, 32'h0, `I2CST_RESP_SLVERR);
		wr(`I2CST_IDX_TIMER, 32'h4);
		repeat (17000) @(posedge aclk);
		rd(`I2CST_IDX_TIMER, 32'h4);
		wr(`I2CST_IDX_IRQ_MASK, 32'h3);
		wr(`I2CST_IDX_IRQ_STAT, 32'h3);
		wr(`I2CST_IDX_CTRL, 32'h1);
		repeat (16300) @(posedge aclk);
		rd(`I2CST_IDX_TIMER, 32'h4);
		repeat (200) @(posedge aclk);
		rd(`I2CST_IDX_TIMER, 32'h5);
		rd(`I2CST_IDX_IRQ_STAT, 32'h2);
		irq_is(1'h1);
		wr(`I2CST_IDX_TIMER, 32'h0);
		rd(`I2CST_IDX_TIMER, 32'h0);
		wr(`I2CST_IDX_IRQ_STAT, 32'h3);
		irq_is(1'h0);
		wr(`I2CST_IDX_TIMER, 32'h6);
		repeat (17000) @(posedge aclk);
		rd(`I2CST_IDX_TIMER, 32'h6);
		wr(`I2CST_IDX_TIMER, 32'h0);
		i_i2cst_bus_partner.start_cond();
		rd(`I2CST_IDX_STATUS, 32'h08);
		rd(`I2CST_IDX_IRQ_STAT, 32'h1);
		irq_is(1'h1);
		i_i2cst_bus_partner.send_bits({8'hA5, 1'h1}, 9);
		rd(`I2CST_IDX_STATUS, 32'h50);
		rd(`I2CST_IDX_DATA, 32'hA5);
		wr(`I2CST_IDX_STATUS, 32'h0);
		rd(`I2CST_IDX_STATUS, 32'h50);
		wr(`I2CST_IDX_IRQ_STAT, 32'h1);
		rd(`I2CST_IDX_STATUS, 32'hF8);
		irq_is(1'h0);
		i_i2cst_bus_partner.stop_cond();
		rd(`I2CST_IDX_STATUS, 32'hA0);
		wr(`I2CST_IDX_IRQ_MASK, 32'h0);
		irq_is(1'h0);
		wr(`I2CST_IDX_IRQ_STAT, 32'h1);
		i_i2cst_bus_partner.start_cond();
		i_i2cst_bus_partner.send_bits(9'h1FF, 3);
		i_i2cst_bus_partner.stop_cond();
		rd(`I2CST_IDX_STATUS, 32'h00);
		wr(`I2CST_IDX_IRQ_STAT, 32'h1);
		rd(`I2CST_IDX_STATUS, 32'hF8);
		// own transmit: nine bits, each half rate+1 cycles, sda pulled only for zero data bits
		wr(`I2CST_IDX_RATE, 32'h3);
		wr(`I2CST_IDX_DATA, 32'h5A);
		wr(`I2CST_IDX_CTRL, 32'h3);
		rd(`I2CST_IDX_CTRL, 32'h3);
		repeat (100) @(posedge aclk);
		rd(`I2CST_IDX_CTRL, 32'h1);
		chk(scl_low_n, 32'h24);
		chk(sda_low_n, 32'h20);
		conclude();
	end
endmodule : i2cst_regs_test
